// ===== inc/rce_fifo_if.sv
`timescale 1ns/10ps
interface rce_fifo_if #(parameter int WIDTH = 8);
	logic wr_valid;
	logic wr_ready;
	logic [WIDTH-1:0] wr_data;
	logic rd_valid;
	logic rd_ready;
	logic [WIDTH-1:0] rd_data;
	modport fifo (input wr_valid, wr_data, rd_ready,
		output wr_ready, rd_valid, rd_data);
	modport user (output wr_valid, wr_data, rd_ready,
		input wr_ready, rd_valid, rd_data);
endinterface : rce_fifo_if

// ===== inc/rce_pkg.sv
package rce_pkg;
	// clock and serial bit rates
	localparam int CLK_HZ = 125_000_000;
	localparam int RATE0_BPS = 2_400;
	localparam int RATE1_BPS = 9_600;
	localparam int RATE2_BPS = 19_200;
	localparam int RATE3_BPS = 28_800;
	// bit periods in clocks, rounded down
	localparam int DIV0_CYC = CLK_HZ / RATE0_BPS;
	localparam int DIV1_CYC = CLK_HZ / RATE1_BPS;
	localparam int DIV2_CYC = CLK_HZ / RATE2_BPS;
	localparam int DIV3_CYC = CLK_HZ / RATE3_BPS;
	localparam int DIV_W = 16;
	// ready indication toggles every half period
	localparam int TOGGLE_HALF_MS = 250;
	localparam int TOGGLE_CYC = CLK_HZ / 1000 * TOGGLE_HALF_MS;
	localparam int TOGGLE_W = 25;
	// packet layout
	localparam int ID_W = 24;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int PKT_BYTES = 4;
	localparam logic [2:0] LAST_BYTE = 3'h3;
	localparam logic [3:0] FRAME_LAST = 4'h9;
	localparam logic [23:0] LFSR_SEED = 24'hA5_0F3C;
	localparam logic [23:0] LFSR_TAPS = 24'hE1_0000;
	// apb map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_ID = 8'h08;
	localparam logic [7:0] ADDR_PAYLOAD = 8'h0C;
	localparam logic [7:0] ADDR_PKTCNT = 8'h10;
	localparam logic [1:0] CTRL_RESET = 2'h3;
	localparam int CTRL_SEND_EN = 0;
	localparam int CTRL_CREATE_EN = 1;
	// encoder states, one-hot
	typedef enum logic [5:0] {
		ST_INIT = 6'b000001,
		ST_SLEEP = 6'b000010,
		ST_BUILD = 6'b000100,
		ST_DRAIN = 6'b001000,
		ST_CREATE = 6'b010000,
		ST_READY = 6'b100000
	} rce_state_t;
endpackage : rce_pkg

// ===== src/rce_encoder.sv
// Function
// R1 - a rising send request latches the eight button inputs as payload.
// R2 - after send rises, identifier and payload go out serially at the rate.
// R3 - the two rate-select pins choose one of four bit rates.
// R4 - the rate pins are settled before power-up, as they are read only then.
// R5 - transmitter power goes high when the send request goes high.
// R6 - transmitter power drops after send falls and stays low while asleep.
// R7 - the create indicator is high for the whole create period.
// R8 - a high create request enters create mode and starts a new identifier.
// R9 - the candidate changes while create is high and is stored when it falls.
// R10 - the identifier is a 24-bit word, fixed between create operations; an apb write to ADDR_ID also changes it.
// R11 - the surrounding circuit keeps every input at a defined level.
// R12 - the eight parallel inputs become an encoded serial bit stream.
// R13 - rate pins high first map 00 2400, 01 9600, 10 19200, 11 28800 bps.
// R14 - rate latched at power-up, then send high sends, else power low, sleep.
// R15 - packets repeat with fresh inputs while send is high; the last ends.
// R16 - after a new identifier is stored the create indicator toggles.
// R17 - a divider set by the latched rate times each bit; the line idles low.
`timescale 1ns/10ps
module rce_encoder import rce_pkg::*; #(
	parameter int DIV0 = DIV0_CYC,
	parameter int DIV1 = DIV1_CYC,
	parameter int DIV2 = DIV2_CYC,
	parameter int DIV3 = DIV3_CYC,
	parameter int TOGGLE = TOGGLE_CYC,
	parameter logic [ID_W-1:0] FACTORY_ID = 24'h5A_C3E1 // arbitrary value
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [DATA_W-1:0] button_inputs_i,
	input wire logic rate_select_low_i,
	input wire logic rate_select_high_i,
	input wire logic send_request_i,
	input wire logic create_request_i,
	output logic serial_data_o,
	output logic transmitter_power_ctl_o,
	output logic create_indicator_o,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o
);
	rce_state_t state;
	rce_state_t next_state;
	logic [1:0] rate;
	logic send_q;
	logic create_q;
	logic [DATA_W-1:0] payload;
	logic [ID_W-1:0] stored_id;
	logic [ID_W-1:0] lfsr;
	logic [2:0] byte_idx;
	logic [1:0] ctrl;
	logic [31:0] pkt_count;
	logic [TOGGLE_W-1:0] tog_cnt;
	logic ser_busy;
	logic [9:0] shreg;
	logic [3:0] bit_idx;
	logic [DIV_W-1:0] baud_cnt;
	logic send_rise;
	logic create_go;
	logic send_go;
	logic tx_idle;
	logic apb_wr;

	rce_fifo_if #(.WIDTH(DATA_W)) bytes_if ();

	rce_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.port(bytes_if)
	);

	// bit period for a rate code
	function automatic logic [DIV_W-1:0] bit_div(input logic [1:0] code);
		case (code)
			2'b00: bit_div = DIV_W'(DIV0);
			2'b01: bit_div = DIV_W'(DIV1);
			2'b10: bit_div = DIV_W'(DIV2);
			default: bit_div = DIV_W'(DIV3);
		endcase
	endfunction : bit_div

	// packet byte by index: identifier high first, then payload
	function automatic logic [DATA_W-1:0] pkt_byte(input logic [2:0] idx,
		input logic [ID_W-1:0] id, input logic [DATA_W-1:0] data);
		case (idx)
			3'h0: pkt_byte = id[23:16];
			3'h1: pkt_byte = id[15:8];
			3'h2: pkt_byte = id[7:0];
			default: pkt_byte = data;
		endcase
	endfunction : pkt_byte

	assign send_rise = send_request_i && !send_q;
	assign send_go = send_request_i && ctrl[CTRL_SEND_EN];
	assign create_go = create_request_i && ctrl[CTRL_CREATE_EN];
	assign tx_idle = !ser_busy && !bytes_if.rd_valid;
	assign apb_wr = psel_i && penable_i && pready_o && pwrite_i;

	// request edge history
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			send_q <= 1'b0;
			create_q <= 1'b0;
		end else begin
			send_q <= send_request_i;
			create_q <= create_request_i;
		end
	end

	// rate pins read once, in the first cycle after reset
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			rate <= 2'b00;
		end else if (state == ST_INIT) begin
			rate <= {rate_select_high_i, rate_select_low_i}; // R3 R13 R14
		end
	end

	// next state
	always_comb begin
		next_state = state;
		case (state)
			ST_INIT: begin
				next_state = send_go ? ST_BUILD : ST_SLEEP; // R14
			end
			ST_SLEEP: begin
				if (create_go) begin
					next_state = ST_CREATE; // R8
				end else if (send_go) begin
					next_state = ST_BUILD;
				end
			end
			ST_BUILD: begin
				if (bytes_if.wr_ready && byte_idx == LAST_BYTE) begin
					next_state = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				if (tx_idle) begin
					next_state = send_go ? ST_BUILD : ST_SLEEP; // R15
				end
			end
			ST_CREATE: begin
				if (!create_request_i) begin
					next_state = ST_READY; // R9
				end
			end
			ST_READY: begin
				if (create_go) begin
					next_state = ST_CREATE;
				end else if (send_go) begin
					next_state = ST_BUILD;
				end
			end
			default: begin
				next_state = ST_SLEEP;
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state <= ST_INIT;
		end else begin
			state <= next_state;
		end
	end

	// payload sampled on each packet start
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			payload <= '0;
		end else if (next_state == ST_BUILD && state != ST_BUILD) begin
			payload <= button_inputs_i; // R1 R15
		end
	end

	// packet bytes pushed into the fifo, stalled by its ready
	always_ff @(posedge core_clk_i) begin
		if (reset_i || state != ST_BUILD) begin
			byte_idx <= '0;
		end else if (bytes_if.wr_ready) begin
			byte_idx <= byte_idx + 1'b1; // R2 R12
		end
	end
	assign bytes_if.wr_valid = (state == ST_BUILD);
	assign bytes_if.wr_data = pkt_byte(byte_idx, stored_id, payload);
	assign bytes_if.rd_ready = !ser_busy;

	// serializer: start bit high, eight bits lsb first, stop low
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ser_busy <= 1'b0;
			shreg <= '0;
			bit_idx <= '0;
			baud_cnt <= '0;
		end else if (!ser_busy) begin
			if (bytes_if.rd_valid) begin
				ser_busy <= 1'b1;
				shreg <= {1'b0, bytes_if.rd_data, 1'b1}; // R12
				bit_idx <= '0;
				baud_cnt <= bit_div(rate) - 1'b1; // R17
			end
		end else if (baud_cnt != '0) begin
			baud_cnt <= baud_cnt - 1'b1;
		end else if (bit_idx == FRAME_LAST) begin
			ser_busy <= 1'b0;
		end else begin
			shreg <= {1'b0, shreg[9:1]};
			bit_idx <= bit_idx + 1'b1;
			baud_cnt <= bit_div(rate) - 1'b1; // R3 R13 R17
		end
	end

	// line output, low when idle
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			serial_data_o <= 1'b0;
		end else begin
			serial_data_o <= ser_busy && shreg[0]; // R2 R17
		end
	end

	// transmitter power follows the send session
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			transmitter_power_ctl_o <= 1'b0;
		end else if (next_state == ST_BUILD) begin
			transmitter_power_ctl_o <= 1'b1; // R5
		end else if (next_state != ST_DRAIN) begin
			transmitter_power_ctl_o <= 1'b0; // R6
		end
	end

	// free-running random source
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			lfsr <= LFSR_SEED;
		end else begin
			lfsr <= {lfsr[22:0], ^(lfsr & LFSR_TAPS)}; // R9
		end
	end

	// identifier store, written only when create ends or by software
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			stored_id <= FACTORY_ID;
		end else if (state == ST_CREATE && !create_request_i) begin
			stored_id <= lfsr; // R9 R10
		end else if (apb_wr && paddr_i == ADDR_ID) begin
			stored_id <= pwdata_i[ID_W-1:0];
		end
	end

	// indicator: steady in create, toggling once ready
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			create_indicator_o <= 1'b0;
			tog_cnt <= '0;
		end else if (next_state == ST_CREATE) begin
			create_indicator_o <= 1'b1; // R7 R8
			tog_cnt <= '0;
		end else if (next_state == ST_READY) begin
			if (tog_cnt == TOGGLE_W'(TOGGLE - 1)) begin
				create_indicator_o <= !create_indicator_o; // R16
				tog_cnt <= '0;
			end else begin
				tog_cnt <= tog_cnt + 1'b1;
			end
		end else begin
			create_indicator_o <= 1'b0;
			tog_cnt <= '0;
		end
	end

	// packets completed
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pkt_count <= '0;
		end else if (state == ST_BUILD && next_state == ST_DRAIN) begin
			pkt_count <= pkt_count + 1'b1;
		end
	end

	// control register
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ctrl <= CTRL_RESET;
		end else if (apb_wr && paddr_i == ADDR_CTRL) begin
			ctrl <= pwdata_i[1:0];
		end
	end

	// apb answer one cycle into the access phase
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= '0;
		end else if (psel_i && penable_i && !pready_o) begin
			pready_o <= 1'b1;
			pslverr_o <= 1'b0;
			prdata_o <= '0;
			case (paddr_i)
				ADDR_CTRL: prdata_o <= {30'h0000_0000, ctrl};
				ADDR_STATUS: prdata_o <= {21'h00_0000, ser_busy,
					send_request_i, rate, 1'b0, state};
				ADDR_ID: prdata_o <= {8'h00, stored_id};
				ADDR_PAYLOAD: prdata_o <= {24'h00_0000, payload};
				ADDR_PKTCNT: prdata_o <= pkt_count;
				default: pslverr_o <= 1'b1;
			endcase
		end else begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	a_power_on_send: assert property ( // R5
		state == ST_SLEEP && send_go && !create_go
		|=> transmitter_power_ctl_o && state == ST_BUILD)
		else $error("power not raised on send");
	a_power_low_sleep: assert property ( // R6
		state == ST_SLEEP |-> !transmitter_power_ctl_o)
		else $error("power high while asleep");
	a_payload_latch: assert property ( // R1
		state == ST_SLEEP && send_go && !create_go
		|=> payload == $past(button_inputs_i))
		else $error("payload not latched");
	a_indicator_create: assert property ( // R7
		state == ST_CREATE |-> create_indicator_o)
		else $error("indicator low in create");
	a_id_store: assert property ( // R9
		state == ST_CREATE && !create_request_i
		|=> stored_id == $past(lfsr) && state == ST_READY)
		else $error("identifier not stored");
	a_id_hold: assert property ( // R10
		!(state == ST_CREATE) && !apb_wr |=> $stable(stored_id))
		else $error("identifier changed");
	a_line_idle: assert property ( // R17
		!$past(ser_busy) |-> !serial_data_o)
		else $error("line not idle low");
	a_start_bit: assert property ( // R2
		!ser_busy && bytes_if.rd_valid |=> ##1 serial_data_o)
		else $error("start bit missing");
	a_rate_fixed: assert property ( // R3
		state != ST_INIT && $past(state) != ST_INIT |-> $stable(rate))
		else $error("rate changed after power-up");
	a_drain_done: assert property ( // R15
		state == ST_DRAIN && tx_idle && !send_go |=> state == ST_SLEEP)
		else $error("no sleep after last packet");

	c_packet: cover property (state == ST_BUILD ##1 state == ST_DRAIN);
	c_repeat: cover property (state == ST_DRAIN ##1 state == ST_BUILD);
	c_create: cover property (state == ST_CREATE ##1 state == ST_READY);
	c_power_up_send: cover property (state == ST_INIT ##1 state == ST_BUILD);
endmodule : rce_encoder

// ===== src/rce_fifo.sv
`timescale 1ns/10ps
module rce_fifo import rce_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	rce_fifo_if.fifo port
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	// honest flags from the occupancy count
	assign port.wr_ready = (count != (AW+1)'(DEPTH));
	assign port.rd_valid = (count != '0);
	assign port.rd_data = mem[rd_ptr];
	assign push = port.wr_valid && port.wr_ready;
	assign pop = port.rd_valid && port.rd_ready;

	// storage write
	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem[wr_ptr] <= port.wr_data;
		end
	end

	// pointers wrap at depth
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
		end
	end

	// occupancy
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			count <= '0;
		end else if (push && !pop) begin
			count <= count + 1'b1;
		end else if (pop && !push) begin
			count <= count - 1'b1;
		end
	end
endmodule : rce_fifo

// ===== verification/rce_rf_model.sv
`timescale 1ns/10ps
module rce_rf_model import rce_pkg::*; (
	input wire logic core_clk_i,
	input wire logic power_i,
	input wire logic line_i,
	input wire logic [15:0] bit_cyc_i
);
	logic [7:0] rx_q[$];
	logic [7:0] rx_byte;
	int n_bad_stop;
	// receiver: samples each bit mid-period, only while powered
	initial begin
		n_bad_stop = 0;
		forever begin
			@(posedge core_clk_i);
			if (power_i === 1'b1 && line_i === 1'b1) begin
				repeat (bit_cyc_i / 2) @(posedge core_clk_i);
				for (int i = 0; i < 8; i++) begin
					repeat (bit_cyc_i) @(posedge core_clk_i);
					rx_byte[i] = line_i;
				end
				repeat (bit_cyc_i) @(posedge core_clk_i);
				if (line_i !== 1'b0) begin
					n_bad_stop++;
				end
				rx_q.push_back(rx_byte);
			end
		end
	end
endmodule : rce_rf_model

// ===== verification/remote_control_encoder_tb_top.sv
`timescale 1ns/10ps
module remote_control_encoder_tb_top import rce_pkg::*;;
	logic core_clk, reset, rsl, rsh, send, create, psel, penable, pwrite;
	logic [7:0] btn, paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, er, ser, power, ind;
	logic [15:0] bit_cyc;
	logic [23:0] id1;
	int n_mismatch, samples_checked, k;
	rce_encoder #(.DIV0(16), .DIV1(12), .DIV2(8), .DIV3(6),
		.TOGGLE(8), .FACTORY_ID(24'h6B_D2F0)) u_dut (
		.core_clk_i(core_clk), .reset_i(reset),
		.button_inputs_i(btn), .rate_select_low_i(rsl),
		.rate_select_high_i(rsh), .send_request_i(send),
		.create_request_i(create), .serial_data_o(ser),
		.transmitter_power_ctl_o(power), .create_indicator_o(ind),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr));
	rce_rf_model u_model (.core_clk_i(core_clk), .power_i(power),
		.line_i(ser), .bit_cyc_i(bit_cyc));
	// 125 MHz clock
	always #4 core_clk = ~core_clk;
	task finish_test();
		$display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	task cmp_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_word
	task cmp_bit(input logic got, input logic exp);
		cmp_word({31'h0, got}, {31'h0, exp});
	endtask : cmp_bit
	// one apb transfer; waits for pready under a bound
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_mismatch++;
			finish_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	task wait_bytes(input int n);
		k = 0;
		while (u_model.rx_q.size() < n && k < 30000) begin
			@(posedge core_clk);
			k++;
		end
		if (k >= 30000) begin
			n_mismatch++;
			finish_test();
		end
	endtask : wait_bytes
	// ends a send session and waits for power to drop
	task end_send();
		send <= 1'b0;
		k = 0;
		while (power !== 1'b0 && k < 30000) begin
			@(posedge core_clk);
			k++;
		end
		if (k >= 30000) begin
			n_mismatch++;
			finish_test();
		end
		repeat (20) @(posedge core_clk);
		cmp_bit(ser, 1'b0);
	endtask : end_send
	task check_packet(input int b, input logic [23:0] id, input logic [7:0] pl);
		cmp_word({24'h0, u_model.rx_q[b]}, {24'h0, id[23:16]});
		cmp_word({24'h0, u_model.rx_q[b+1]}, {24'h0, id[15:8]});
		cmp_word({24'h0, u_model.rx_q[b+2]}, {24'h0, id[7:0]});
		cmp_word({24'h0, u_model.rx_q[b+3]}, {24'h0, pl});
	endtask : check_packet
	// hang guard
	initial begin
		repeat (100000) @(posedge core_clk);
		n_mismatch++;
		finish_test();
	end
	// main sequence
	initial begin
		core_clk = 0;
		reset = 1;
		rsl = 0;
		rsh = 0;
		send = 0;
		create = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		btn = 0;
		n_mismatch = 0;
		samples_checked = 0;
		bit_cyc = 16;
		for (int r = 0; r < 4; r++) begin
			reset <= 1'b1;
			{rsh, rsl} <= r[1:0];
			bit_cyc <= 16'((r == 0) ? 16 : (r == 1) ? 12 : (r == 2) ? 8 : 6);
			repeat (12) @(posedge core_clk);
			reset <= 1'b0;
			repeat (2) @(posedge core_clk);
			cmp_bit(power, 1'b0);
			apb(1'b0, ADDR_STATUS, 32'h0);
			cmp_word(rd, {23'h0, r[1:0], 7'h02});
			apb(1'b0, ADDR_CTRL, 32'h0);
			cmp_word(rd, 32'h0000_0003);
			apb(1'b1, ADDR_ID, 32'h0012_3456 + r);
			u_model.rx_q.delete();
			btn <= 8'hA5 ^ r[7:0];
			send <= 1'b1;
			repeat (2) @(posedge core_clk);
			cmp_bit(power, 1'b1);
			wait_bytes(1);
			end_send();
			cmp_word(u_model.rx_q.size() % 4, 0);
			check_packet(0, 24'(24'h12_3456 + r), 8'hA5 ^ r[7:0]);
		end
		apb(1'b0, 8'h14, 32'h0);
		cmp_bit(er, 1'b1);
		cmp_word(rd, 32'h0);
		// repeated packets with a payload change in mid-session
		u_model.rx_q.delete();
		btn <= 8'h5A;
		send <= 1'b1;
		wait_bytes(4);
		btn <= 8'h3C;
		wait_bytes(40);
		end_send();
		cmp_word(u_model.rx_q.size() % 4, 0);
		check_packet(0, 24'h12_3459, 8'h5A);
		check_packet(u_model.rx_q.size() - 4, 24'h12_3459, 8'h3C);
		apb(1'b0, ADDR_PAYLOAD, 32'h0);
		cmp_word(rd, 32'h0000_003C);
		apb(1'b0, ADDR_PKTCNT, 32'h0);
		cmp_word(rd, 1 + u_model.rx_q.size() / 4);
		cmp_word(u_model.n_bad_stop, 0);
		// create a new identifier
		create <= 1'b1;
		repeat (2) @(posedge core_clk);
		for (int i = 0; i < 30; i++) begin
			cmp_bit(ind, 1'b1);
			@(posedge core_clk);
		end
		create <= 1'b0;
		repeat (4) @(posedge core_clk);
		apb(1'b0, ADDR_STATUS, 32'h0);
		cmp_word(rd, 32'h0000_01A0);
		apb(1'b0, ADDR_ID, 32'h0);
		id1 = rd[23:0];
		cmp_bit(id1 !== 24'h12_3459, 1'b1);
		for (int t = 0; t < 3; t++) begin
			er = ind;
			k = 0;
			while (ind === er && k < 12) begin
				@(posedge core_clk);
				k++;
			end
			cmp_bit(k < 12, 1'b1);
		end
		apb(1'b0, ADDR_ID, 32'h0);
		cmp_word(rd, {8'h0, id1});
		u_model.rx_q.delete();
		btn <= 8'h81;
		send <= 1'b1;
		wait_bytes(1);
		end_send();
		check_packet(0, id1, 8'h81);
		// power-up with send already high goes straight to sending
		reset <= 1'b1;
		send <= 1'b1;
		btn <= 8'h42;
		u_model.rx_q.delete();
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		repeat (2) @(posedge core_clk);
		cmp_bit(power, 1'b1);
		wait_bytes(1);
		end_send();
		check_packet(0, 24'h6B_D2F0, 8'h42);
		finish_test();
	end
endmodule : remote_control_encoder_tb_top
